// ===== rtl/flash_pwr_pkg.sv
// Purpose: Shared constants and types for the flash wake and power-up control ends
// Assumes: 100 MHz system clock on both ends
// Notes: Instruction codes are plain defaults

package flash_pwr_pkg;

  localparam int CLK_MHZ = 100;

  // Least delay from supply good to first select
  localparam int SELECT_DELAY_US = 30;
  localparam int SELECT_CYCLES = SELECT_DELAY_US * CLK_MHZ;
  // Write lockout after supply good
  localparam int UNLOCK_DELAY_MS = 1;
  localparam int UNLOCK_CYCLES = UNLOCK_DELAY_MS * 1000 * CLK_MHZ;
  localparam int WAKE_DELAY_US = 3;
  localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
  localparam int SLEEP_DELAY_US = 3;
  localparam int SLEEP_CYCLES = SLEEP_DELAY_US * CLK_MHZ;
  // Self-timed modify cycle length
  localparam int MODIFY_TIME_US = 100;
  localparam int MODIFY_CYCLES = MODIFY_TIME_US * CLK_MHZ;

  localparam int SCLK_HALF = 8;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_BYTES = 3;

  localparam logic [7:0] WAKE_CMD = 8'hab;
  localparam logic [7:0] SLEEP_CMD = 8'hb9;
  localparam logic [7:0] MODIFY_ARM_CMD = 8'h06;
  localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0a;
  localparam logic [7:0] PAGE_FILL_CMD = 8'h02;
  localparam logic [7:0] PAGE_CLEAR_CMD = 8'hdb;
  localparam logic [7:0] BLOCK_CLEAR_CMD = 8'hd8;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] DATA_READ_CMD = 8'h03;

  localparam int CYCLE_ACTIVE_BIT = 0;
  localparam int MODIFY_PERMIT_BIT = 1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef enum logic [2:0] {
    PWR_RESET,
    PWR_STANDBY,
    PWR_SLEEP_ENTRY,
    PWR_SLEEP,
    PWR_WAKING
  } pwr_state_t;

  typedef enum logic [1:0] {
    OP_FILL,
    OP_REWRITE,
    OP_CLEAR
  } modify_op_t;

endpackage

// ===== rtl/flash_link_if.sv
// Purpose: Four-wire serial link plus reset pin between host and flash
// Assumes: Host drives clock, select, data in and reset pin
// Notes: No two-way pins

`timescale 1ns/10ps

interface flash_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic rst_n;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    input rst_n,
    output miso
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    output rst_n,
    input miso
  );
endinterface

// ===== rtl/flash_wake_dev.sv
// Purpose: Flash end: power-up gating, deep sleep entry and wake, self-timed cycles
// Assumes: Link pins and supply good are asynchronous and pass two flip-flops
// Notes: A small page of the array is modelled; it survives supply loss

`timescale 1ns/10ps
module flash_wake_dev #(
  parameter int SELECT_CYCLES = flash_pwr_pkg::SELECT_CYCLES,
  parameter int UNLOCK_CYCLES = flash_pwr_pkg::UNLOCK_CYCLES,
  parameter int WAKE_CYCLES = flash_pwr_pkg::WAKE_CYCLES,
  parameter int SLEEP_CYCLES = flash_pwr_pkg::SLEEP_CYCLES,
  parameter int MODIFY_CYCLES = flash_pwr_pkg::MODIFY_CYCLES,
  parameter int PAGE_BYTES = flash_pwr_pkg::PAGE_BYTES
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Supply monitor
  input wire logic supply_good_i,
  // Serial link
  flash_link_if.dev link,
  // Status towards the user side
  output flash_pwr_pkg::pwr_state_t state_o,
  output logic cycle_active_o,
  output logic modify_permit_o,
  output logic read_allowed_o,
  output logic write_allowed_o,
  output logic cmd_done_o,
  output logic cmd_reject_o,
  output logic [7:0] cmd_code_o
);
  localparam int AW = $clog2(PAGE_BYTES);
  typedef struct packed {
    logic [1:0] sclk_s, cs_s, mosi_s, rstp_s, pg_s;
    logic sclk_p, cs_p;
    flash_pwr_pkg::pwr_state_t st;
    flash_pwr_pkg::modify_op_t op;
    logic modify_permit_flag, cycle_active_flag, rd_ok, wr_ok;
    logic [31:0] pu_cnt, dly_cnt, cyc_cnt;
    logic [15:0] bit_cnt;
    logic [7:0] sh, cmd;
    logic [23:0] addr;
    logic [7:0] out_sr;
    logic done, rej;
    logic [7:0] code;
    logic [PAGE_BYTES-1:0][7:0] mem, stage;
    logic [PAGE_BYTES-1:0] mask;
  } dev_state_t;
  dev_state_t r_q, r_d;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic selected, listen, is_modify;
  logic [7:0] in_byte;
  logic [15:0] nbytes;
  logic [AW-1:0] idx;

  always_comb begin
    r_d = r_q;
    r_d.sclk_s = {r_q.sclk_s[0], link.sclk};
    r_d.cs_s = {r_q.cs_s[0], link.cs_n};
    r_d.mosi_s = {r_q.mosi_s[0], link.mosi};
    r_d.rstp_s = {r_q.rstp_s[0], link.rst_n};
    r_d.pg_s = {r_q.pg_s[0], supply_good_i};
    r_d.sclk_p = r_q.sclk_s[1];
    r_d.cs_p = r_q.cs_s[1];
    r_d.done = 1'b0;
    r_d.rej = 1'b0;
    sclk_rise = r_q.sclk_s[1] & ~r_q.sclk_p;
    sclk_fall = ~r_q.sclk_s[1] & r_q.sclk_p;
    cs_fall = ~r_q.cs_s[1] & r_q.cs_p;
    cs_rise = r_q.cs_s[1] & ~r_q.cs_p;
    selected = ~r_q.cs_s[1];
    in_byte = {r_q.sh[6:0], r_q.mosi_s[1]};
    nbytes = r_q.bit_cnt >> 3;
    idx = AW'(r_q.addr[AW-1:0] + nbytes[AW-1:0] - AW'(4));
    is_modify = (r_q.cmd == flash_pwr_pkg::PAGE_FILL_CMD)
             || (r_q.cmd == flash_pwr_pkg::PAGE_REWRITE_CMD)
             || (r_q.cmd == flash_pwr_pkg::PAGE_CLEAR_CMD)
             || (r_q.cmd == flash_pwr_pkg::BLOCK_CLEAR_CMD);
    listen = ((r_q.st == flash_pwr_pkg::PWR_STANDBY) && r_q.rd_ok)
          || (r_q.st == flash_pwr_pkg::PWR_SLEEP);
    // Power-up timers restart whenever the supply dips
    if (!r_q.pg_s[1]) begin
      r_d.pu_cnt = '0;
    end else if (r_q.pu_cnt < 32'(UNLOCK_CYCLES)) begin
      r_d.pu_cnt = r_q.pu_cnt + 32'd1;
    end
    r_d.rd_ok = r_q.pg_s[1] && (r_q.pu_cnt >= 32'(SELECT_CYCLES));
    r_d.wr_ok = r_q.pg_s[1] && (r_q.pu_cnt >= 32'(UNLOCK_CYCLES));
    if (!r_q.pg_s[1] || !r_q.rstp_s[1]) begin
      // Logic held in reset; any running cycle is abandoned, array kept
      r_d.st = flash_pwr_pkg::PWR_RESET;
      r_d.modify_permit_flag = 1'b0;
      r_d.cycle_active_flag = 1'b0;
      r_d.bit_cnt = '0;
      r_d.out_sr = '0;
      r_d.dly_cnt = '0;
      r_d.cyc_cnt = '0;
    end else begin
      unique case (r_q.st)
        flash_pwr_pkg::PWR_RESET: r_d.st = flash_pwr_pkg::PWR_STANDBY;
        flash_pwr_pkg::PWR_SLEEP_ENTRY: begin
          r_d.dly_cnt = r_q.dly_cnt + 32'd1;
          if (r_q.dly_cnt >= 32'(SLEEP_CYCLES - 1)) begin
            r_d.st = flash_pwr_pkg::PWR_SLEEP;
          end
        end
        flash_pwr_pkg::PWR_WAKING: begin
          r_d.dly_cnt = r_q.dly_cnt + 32'd1;
          if (r_q.dly_cnt >= 32'(WAKE_CYCLES - 1)) begin
            r_d.st = flash_pwr_pkg::PWR_STANDBY;
          end
        end
        flash_pwr_pkg::PWR_STANDBY, flash_pwr_pkg::PWR_SLEEP: ;
      endcase
      if (r_q.cycle_active_flag) begin
        r_d.cyc_cnt = r_q.cyc_cnt + 32'd1;
        if (r_q.cyc_cnt >= 32'(MODIFY_CYCLES - 1)) begin
          r_d.cycle_active_flag = 1'b0;
          r_d.modify_permit_flag = 1'b0;
          for (int i = 0; i < PAGE_BYTES; i++) begin
            unique case (r_q.op)
              flash_pwr_pkg::OP_CLEAR: r_d.mem[i] = flash_pwr_pkg::ERASED_BYTE;
              flash_pwr_pkg::OP_FILL: r_d.mem[i] = r_q.mem[i] & r_q.stage[i];
              flash_pwr_pkg::OP_REWRITE: r_d.mem[i] = r_q.mask[i] ? r_q.stage[i] : r_q.mem[i];
              default: r_d.mem[i] = r_q.mem[i];
            endcase
          end
        end
      end
      // Frame start; the staging page is frozen while a cycle runs
      if (cs_fall) begin
        r_d.bit_cnt = '0;
        r_d.cmd = '0;
        if (!r_q.cycle_active_flag) begin
          r_d.stage = '1;
          r_d.mask = '0;
        end
      end
      if (selected && sclk_rise) begin
        r_d.sh = in_byte;
        if (r_q.bit_cnt != 16'hffff) begin
          r_d.bit_cnt = r_q.bit_cnt + 16'd1;
        end
        if (r_q.bit_cnt[2:0] == 3'd7) begin
          if (nbytes == 16'd0) begin
            r_d.cmd = in_byte;
          end else if (nbytes <= 16'(flash_pwr_pkg::ADDR_BYTES)) begin
            r_d.addr = {r_q.addr[15:0], in_byte};
          end else if (!r_q.cycle_active_flag && (r_q.st == flash_pwr_pkg::PWR_STANDBY)) begin
            r_d.stage[idx] = in_byte;
            r_d.mask[idx] = 1'b1;
          end
        end
      end
      // Serial answers only in standby after the select delay
      if (!selected || !listen || (r_q.st != flash_pwr_pkg::PWR_STANDBY)) begin
        r_d.out_sr = '0;
      end else if (sclk_fall) begin
        if ((r_q.bit_cnt[2:0] == 3'd0) && (r_q.bit_cnt != 16'd0)) begin
          if (r_q.cmd == flash_pwr_pkg::STATUS_READ_CMD) begin
            r_d.out_sr = '0;
            r_d.out_sr[flash_pwr_pkg::CYCLE_ACTIVE_BIT] = r_q.cycle_active_flag;
            r_d.out_sr[flash_pwr_pkg::MODIFY_PERMIT_BIT] = r_q.modify_permit_flag;
          end else if ((r_q.cmd == flash_pwr_pkg::DATA_READ_CMD) && (nbytes >= 16'd4)) begin
            r_d.out_sr = r_q.mem[idx];
          end else begin
            r_d.out_sr = '0;
          end
        end else begin
          r_d.out_sr = {r_q.out_sr[6:0], 1'b0};
        end
      end
      // Execute on select rise; a frame seen outside listen is dropped
      if (cs_rise && listen && (r_q.bit_cnt != 16'd0)) begin
        r_d.code = r_q.cmd;
        r_d.rej = 1'b1;
        if (r_q.st == flash_pwr_pkg::PWR_SLEEP) begin
          if ((r_q.cmd == flash_pwr_pkg::WAKE_CMD) && (r_q.bit_cnt == 16'd8)
              && !r_q.cycle_active_flag) begin
            r_d.st = flash_pwr_pkg::PWR_WAKING;
            r_d.dly_cnt = '0;
            r_d.rej = 1'b0;
            r_d.done = 1'b1;
          end
        end else if (r_q.cmd == flash_pwr_pkg::SLEEP_CMD) begin
          if (!r_q.cycle_active_flag && (r_q.bit_cnt == 16'd8)) begin
            r_d.st = flash_pwr_pkg::PWR_SLEEP_ENTRY;
            r_d.dly_cnt = '0;
            r_d.rej = 1'b0;
            r_d.done = 1'b1;
          end
        end else if (r_q.cmd == flash_pwr_pkg::MODIFY_ARM_CMD) begin
          if (!r_q.cycle_active_flag && r_q.wr_ok && (r_q.bit_cnt == 16'd8)) begin
            r_d.modify_permit_flag = 1'b1;
            r_d.rej = 1'b0;
            r_d.done = 1'b1;
          end
        end else if (is_modify) begin
          if (!r_q.cycle_active_flag && r_q.wr_ok && r_q.modify_permit_flag && (r_q.bit_cnt[2:0] == 3'd0)) begin
            if ((r_q.cmd == flash_pwr_pkg::PAGE_CLEAR_CMD)
                || (r_q.cmd == flash_pwr_pkg::BLOCK_CLEAR_CMD)) begin
              if (r_q.bit_cnt == 16'd32) begin
                r_d.op = flash_pwr_pkg::OP_CLEAR;
                r_d.cycle_active_flag = 1'b1;
                r_d.cyc_cnt = '0;
                r_d.rej = 1'b0;
                r_d.done = 1'b1;
              end
            end else if (r_q.bit_cnt >= 16'd40) begin
              r_d.op = (r_q.cmd == flash_pwr_pkg::PAGE_FILL_CMD) ?
                flash_pwr_pkg::OP_FILL : flash_pwr_pkg::OP_REWRITE;
              r_d.cycle_active_flag = 1'b1;
              r_d.cyc_cnt = '0;
              r_d.rej = 1'b0;
              r_d.done = 1'b1;
            end
          end
        end else if ((r_q.cmd == flash_pwr_pkg::WAKE_CMD)
                     || (r_q.cmd == flash_pwr_pkg::STATUS_READ_CMD)
                     || (r_q.cmd == flash_pwr_pkg::DATA_READ_CMD)) begin
          // Wake while awake is harmless but still checked for framing
          if ((r_q.cmd != flash_pwr_pkg::WAKE_CMD)
              || ((r_q.bit_cnt == 16'd8) && !r_q.cycle_active_flag)) begin
            r_d.rej = 1'b0;
            r_d.done = 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_q <= '0;
      r_q.cs_s <= 2'b11;
      r_q.cs_p <= 1'b1;
      r_q.st <= flash_pwr_pkg::PWR_RESET;
      r_q.mem <= '1;
      r_q.stage <= '1;
    end else if (clk_en_i) begin
      r_q <= r_d;
    end
  end
  assign link.miso = r_q.out_sr[7];
  assign state_o = r_q.st;
  assign cycle_active_o = r_q.cycle_active_flag;
  assign modify_permit_o = r_q.modify_permit_flag;
  assign read_allowed_o = r_q.rd_ok;
  assign write_allowed_o = r_q.wr_ok;
  assign cmd_done_o = r_q.done;
  assign cmd_reject_o = r_q.rej;
  assign cmd_code_o = r_q.code;
endmodule

// ===== rtl/flash_wake_host.sv
// Purpose: Host end: frames commands on the serial link and keeps power-up timing
// Assumes: Supply good and the returned data line are asynchronous
// Notes: Serial clock is divided down from the system clock

`timescale 1ns/10ps

module flash_wake_host #(
  parameter int SELECT_CYCLES = flash_pwr_pkg::SELECT_CYCLES,
  parameter int UNLOCK_CYCLES = flash_pwr_pkg::UNLOCK_CYCLES,
  parameter int WAKE_CYCLES = flash_pwr_pkg::WAKE_CYCLES,
  parameter int HALF = flash_pwr_pkg::SCLK_HALF
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Supply monitor
  input wire logic supply_good_i,
  // Serial link
  flash_link_if.host link,
  // Request
  input wire logic req_valid_i,
  input wire logic [7:0] req_cmd_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  input wire logic [8:0] req_bytes_i,
  output logic req_ready_o,
  // Answer
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_refused_o
);

  typedef enum logic [2:0] {H_OFF, H_IDLE, H_SHIFT, H_END, H_GAP} host_state_t;

  typedef struct packed {
    logic [1:0] pg_s;
    logic [1:0] miso_s;
    host_state_t st;
    logic [31:0] pu_cnt;
    logic [31:0] cnt;
    logic [11:0] bits;
    logic [11:0] tot;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] data;
    logic [7:0] rx;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic rst_n;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic refused;
  } host_reg_t;

  host_reg_t r_q;
  host_reg_t r_d;

  function automatic logic tx_bit(input host_reg_t r, input logic [11:0] b);
    logic [7:0] byte_v;
    unique case (b[11:3])
      9'd0: byte_v = r.cmd;
      9'd1: byte_v = r.addr[23:16];
      9'd2: byte_v = r.addr[15:8];
      9'd3: byte_v = r.addr[7:0];
      default: byte_v = r.data;
    endcase
    return byte_v[3'd7 - b[2:0]];
  endfunction

  logic is_modify;
  logic [7:0] rx_next;

  always_comb begin
    r_d = r_q;
    r_d.pg_s = {r_q.pg_s[0], supply_good_i};
    r_d.miso_s = {r_q.miso_s[0], link.miso};
    r_d.rsp_valid = 1'b0;
    r_d.refused = 1'b0;
    rx_next = {r_q.rx[6:0], r_q.miso_s[1]};
    is_modify = (req_cmd_i == flash_pwr_pkg::MODIFY_ARM_CMD)
             || (req_cmd_i == flash_pwr_pkg::PAGE_FILL_CMD)
             || (req_cmd_i == flash_pwr_pkg::PAGE_REWRITE_CMD)
             || (req_cmd_i == flash_pwr_pkg::PAGE_CLEAR_CMD)
             || (req_cmd_i == flash_pwr_pkg::BLOCK_CLEAR_CMD);
    if (!r_q.pg_s[1]) begin
      r_d.pu_cnt = '0;
    end else if (r_q.pu_cnt < 32'(UNLOCK_CYCLES)) begin
      r_d.pu_cnt = r_q.pu_cnt + 32'd1;
    end

    if (!r_q.pg_s[1]) begin
      // Deselected and reset pin held through power ramps
      r_d.st = H_OFF;
      r_d.cs_n = 1'b1;
      r_d.sclk = 1'b0;
      r_d.rst_n = 1'b0;
      r_d.ready = 1'b0;
    end else begin
      unique case (r_q.st)
        H_OFF: begin
          if (r_q.pu_cnt >= 32'(SELECT_CYCLES)) begin
            r_d.st = H_IDLE;
            r_d.rst_n = 1'b1;
            r_d.ready = 1'b1;
          end
        end
        H_IDLE: begin
          if (req_valid_i && r_q.ready) begin
            if (is_modify && (r_q.pu_cnt < 32'(UNLOCK_CYCLES))) begin
              r_d.refused = 1'b1;
            end else begin
              r_d.cmd = req_cmd_i;
              r_d.addr = req_addr_i;
              r_d.data = req_data_i;
              r_d.tot = (req_bytes_i == 9'd0) ? 12'd8 : {req_bytes_i, 3'b000};
              r_d.bits = '0;
              r_d.cnt = '0;
              r_d.cs_n = 1'b0;
              r_d.mosi = req_cmd_i[7];
              r_d.ready = 1'b0;
              r_d.st = H_SHIFT;
            end
          end
        end
        H_SHIFT: begin
          r_d.cnt = r_q.cnt + 32'd1;
          if (r_q.cnt >= 32'(HALF - 1)) begin
            r_d.cnt = '0;
            if (!r_q.sclk) begin
              r_d.sclk = 1'b1;
              r_d.rx = rx_next;
              r_d.bits = r_q.bits + 12'd1;
              if (r_q.bits[2:0] == 3'd7) begin
                r_d.rsp_valid = 1'b1;
                r_d.rsp_data = rx_next;
              end
            end else begin
              r_d.sclk = 1'b0;
              if (r_q.bits == r_q.tot) begin
                r_d.st = H_END;
              end else begin
                r_d.mosi = tx_bit(r_q, r_q.bits);
              end
            end
          end
        end
        H_END: begin
          r_d.cnt = r_q.cnt + 32'd1;
          if (r_q.cnt >= 32'(HALF - 1)) begin
            r_d.cs_n = 1'b1;
            r_d.cnt = '0;
            r_d.st = H_GAP;
          end
        end
        H_GAP: begin
          // Wake needs the full delay before the next select
          r_d.cnt = r_q.cnt + 32'd1;
          if (((r_q.cmd == flash_pwr_pkg::WAKE_CMD)
               && (r_q.cnt >= 32'(WAKE_CYCLES - 1)))
              || ((r_q.cmd != flash_pwr_pkg::WAKE_CMD)
               && (r_q.cnt >= 32'(HALF - 1)))) begin
            r_d.st = H_IDLE;
            r_d.ready = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_q <= '0;
      r_q.st <= H_OFF;
      r_q.cs_n <= 1'b1;
    end else if (clk_en_i) begin
      r_q <= r_d;
    end
  end

  assign link.sclk = r_q.sclk;
  assign link.cs_n = r_q.cs_n;
  assign link.mosi = r_q.mosi;
  assign link.rst_n = r_q.rst_n;
  assign req_ready_o = r_q.ready;
  assign rsp_valid_o = r_q.rsp_valid;
  assign rsp_data_o = r_q.rsp_data;
  assign rsp_refused_o = r_q.refused;

endmodule

// ===== tb/flash_wake_properties.sv
// Purpose: Wake, sleep and power-up timing checks on the flash link
// Assumes: Inputs are supply good, the select pin and device status, one clock domain
// Notes: Supply time is counted here, not taken from either end
`timescale 1ns/10ps
module flash_wake_properties #(
  parameter int SELECT_CYCLES = 20,
  parameter int UNLOCK_CYCLES = 200
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Supply and link
  input wire logic supply_good_i,
  input wire logic cs_n,
  // Device status
  input wire flash_pwr_pkg::pwr_state_t state_o,
  input wire logic cycle_active_o,
  input wire logic modify_permit_o,
  input wire logic read_allowed_o,
  input wire logic write_allowed_o,
  input wire logic cmd_done_o,
  input wire logic cmd_reject_o,
  input wire logic [7:0] cmd_code_o
);
  int sup_cnt;

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // Raw supply time; the ends see it two flops later
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sup_cnt <= 0;
    end else begin
      sup_cnt <= supply_good_i ? sup_cnt + 1 : 0;
    end
  end

  AST_SLEEP_ONLY_WAKE: assert property (cmd_done_o && $past(state_o) == flash_pwr_pkg::PWR_SLEEP
    |-> cmd_code_o == flash_pwr_pkg::WAKE_CMD && state_o == flash_pwr_pkg::PWR_WAKING)
    else $error("done in sleep for a command other than wake");
  AST_SLEEP_REJECT_KEEPS: assert property (cmd_reject_o && $past(state_o) == flash_pwr_pkg::PWR_SLEEP
    |-> state_o == flash_pwr_pkg::PWR_SLEEP && !modify_permit_o)
    else $error("rejected command in sleep changed state");
  AST_WAKE_DELAY: assert property ($rose(state_o == flash_pwr_pkg::PWR_WAKING)
    |-> (state_o == flash_pwr_pkg::PWR_WAKING)[*8] ##[1:4] state_o == flash_pwr_pkg::PWR_STANDBY)
    else $error("wake delay length wrong");
  AST_DESELECT_WAKING: assert property ($rose(state_o == flash_pwr_pkg::PWR_WAKING) |-> cs_n[*6])
    else $error("select during wake delay");
  AST_CYCLE_REJECT: assert property (cmd_reject_o && $past(cycle_active_o)
    |-> cycle_active_o && state_o == flash_pwr_pkg::PWR_STANDBY)
    else $error("reject disturbed running cycle");
  AST_SELECT_AFTER_SUPPLY: assert property ($fell(cs_n) |-> sup_cnt >= SELECT_CYCLES)
    else $error("select too soon after supply good");
  AST_SUPPLY_LOSS: assert property ($fell(supply_good_i) |-> ##[1:4]
    (state_o == flash_pwr_pkg::PWR_RESET && !cycle_active_o && !modify_permit_o))
    else $error("supply loss did not reset logic");
  AST_ARM_AFTER_LOCKOUT: assert property ($rose(modify_permit_o)
    |-> write_allowed_o && cmd_code_o == flash_pwr_pkg::MODIFY_ARM_CMD)
    else $error("permit set inside lockout");
  AST_LOCKOUT_LEN: assert property ($rose(write_allowed_o) |-> sup_cnt >= UNLOCK_CYCLES)
    else $error("write lockout too short");
  AST_READ_AFTER_SELECT: assert property ($rose(read_allowed_o) |-> sup_cnt >= SELECT_CYCLES)
    else $error("reads allowed too early");
  AST_POWERUP_STANDBY: assert property ($past(state_o) == flash_pwr_pkg::PWR_RESET
    && state_o != flash_pwr_pkg::PWR_RESET
    |-> state_o == flash_pwr_pkg::PWR_STANDBY && !cycle_active_o && !modify_permit_o)
    else $error("power-up not in clean standby");
  AST_CYCLE_FLAG: assert property ($rose(cycle_active_o)
    |-> (cmd_done_o || $past(cmd_done_o)) ##1 cycle_active_o[*8])
    else $error("cycle flag not tied to a done modify");
endmodule

// ===== tb/flash_wake_and_powerup_control_tb_top.sv
// Purpose: Host and device ends joined on one link, driven from the host request side
// Assumes: Short delay parameters; serial clock 160 ns from the host divider
// Notes: Expected answers queue up in order and are popped as pulses appear
`timescale 1ns/10ps
module flash_wake_and_powerup_control_tb_top;
  localparam int SEL = 20;
  localparam int UNL = 1000;
  localparam int WK = 10;
  localparam int MOD = 2000;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sup = 1'b0;
  logic vld = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [23:0] adr = 24'h00_0000;
  logic [7:0] dat = 8'h00;
  logic [8:0] nb = 9'h001;
  logic rdy, rv, rf, done, rej, act, prm, rda, wra;
  logic [7:0] rd, code;
  flash_pwr_pkg::pwr_state_t st;
  logic [9:0] q[$];
  logic [31:0] lf = 32'he5a3_932c;
  logic [7:0] ops[4] = '{8'h02, 8'h0a, 8'hdb, 8'hd8};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  flash_link_if lk();

  always #5 clock_i = ~clock_i;

  flash_wake_dev #(.SELECT_CYCLES(SEL), .UNLOCK_CYCLES(UNL), .WAKE_CYCLES(WK),
    .SLEEP_CYCLES(WK), .MODIFY_CYCLES(MOD)) i_flash_wake_dev (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .supply_good_i(sup), .link(lk.dev), .state_o(st),
    .cycle_active_o(act), .modify_permit_o(prm), .read_allowed_o(rda), .write_allowed_o(wra),
    .cmd_done_o(done), .cmd_reject_o(rej), .cmd_code_o(code));
  flash_wake_host #(.SELECT_CYCLES(SEL), .UNLOCK_CYCLES(UNL), .WAKE_CYCLES(WK), .HALF(8))
    i_flash_wake_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .supply_good_i(sup), .link(lk.host), .req_valid_i(vld), .req_cmd_i(cmd), .req_addr_i(adr),
    .req_data_i(dat), .req_bytes_i(nb), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rd),
    .rsp_refused_o(rf));
  flash_wake_properties #(.SELECT_CYCLES(SEL), .UNLOCK_CYCLES(UNL)) i_flash_wake_properties (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .supply_good_i(sup), .cs_n(lk.cs_n),
    .state_o(st), .cycle_active_o(act), .modify_permit_o(prm), .read_allowed_o(rda),
    .write_allowed_o(wra), .cmd_done_o(done), .cmd_reject_o(rej), .cmd_code_o(code));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (e !== g) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chks(input flash_pwr_pkg::pwr_state_t e);
    chk({7'h00, e}, {7'h00, st});
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic idle();
    int k;
    k = 0;
    @(negedge clock_i);
    while (rdy !== 1'b1 && k < 5000) begin
      @(negedge clock_i);
      k++;
    end
  endtask

  // res: 0 done, 1 reject, 3 refused by the host; first skip answer bytes read as zero
  task automatic send(input logic [7:0] c, input int n, input logic [23:0] a,
      input logic [1:0] res, input int skip, input logic [7:0] v);
    idle();
    if (res == 2'h3) q.push_back(10'h300);
    else begin
      for (int k = 0; k < n; k++) q.push_back({2'h2, (k < skip) ? 8'h00 : v});
      q.push_back({res, c});
    end
    cmd = c;
    nb = 9'(n);
    adr = a;
    vld = 1'b1;
    @(negedge clock_i);
    vld = 1'b0;
  endtask

  task automatic got(input logic [9:0] g);
    if (q.size() == 0) chk('x, g);
    else chk(q.pop_front(), g);
  endtask

  always @(negedge clock_i) begin
    if (done === 1'b1) got({2'h0, code});
    if (rej === 1'b1) got({2'h1, code});
    if (rv === 1'b1) got({2'h2, rd});
    if (rf === 1'b1) got(10'h300);
  end

  // Hang guard well above the expected run of about 20000 cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    tick(4);
    sys_rst_i = 1'b0;
    tick(3);
    chks(flash_pwr_pkg::PWR_RESET);
    sup = 1'b1;
    send(8'h06, 1, 24'h00_0000, 2'h3, 0, 8'h00);
    send(8'h05, 2, 24'h00_0000, 2'h0, 1, 8'h00);
    chk({9'h000, rda}, 10'h001);
    chk({9'h000, wra}, 10'h000);
    for (int k = 0; k < 2000 && wra !== 1'b1; k++) tick(1);
    chk({9'h000, wra}, 10'h001);
    send(8'h03, 6, lf[23:0], 2'h0, 4, 8'hff);
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      dat = lf[7:0];
      send(8'h06, 1, lf[31:8], 2'h0, 1, 8'h00);
      idle();
      chk({9'h000, prm}, 10'h001);
      send(ops[i], (i < 2) ? 6 : 4, lf[31:8], 2'h0, 6, 8'h00);
      if (i == 0) begin
        idle();
        chk({9'h000, act}, 10'h001);
        send(8'hab, 1, 24'h00_0000, 2'h1, 1, 8'h00);
      end
      idle();
      tick(MOD + 4);
      chk({9'h000, act}, 10'h000);
      send(8'h05, 2, 24'h00_0000, 2'h0, 1, 8'h00);
      send(8'h03, 6, lf[31:8], 2'h0, 4, (i < 2) ? dat : 8'hff);
    end
    send(8'hb9, 1, 24'h00_0000, 2'h0, 1, 8'h00);
    idle();
    tick(WK + 4);
    chks(flash_pwr_pkg::PWR_SLEEP);
    send(8'h06, 1, 24'h00_0000, 2'h1, 1, 8'h00);
    send(8'h05, 2, 24'h00_0000, 2'h1, 2, 8'h00);
    send(8'hab, 2, 24'h00_0000, 2'h1, 2, 8'h00);
    idle();
    chks(flash_pwr_pkg::PWR_SLEEP);
    send(8'hab, 1, 24'h00_0000, 2'h0, 1, 8'h00);
    idle();
    tick(WK);
    chks(flash_pwr_pkg::PWR_STANDBY);
    send(8'h05, 2, 24'h00_0000, 2'h0, 1, 8'h00);
    idle();
    sup = 1'b0;
    tick(8);
    chks(flash_pwr_pkg::PWR_RESET);
    sup = 1'b1;
    idle();
    // Reset pin release reaches the flash end through its synchroniser
    tick(4);
    chks(flash_pwr_pkg::PWR_STANDBY);
    send(8'h03, 6, 24'h00_0000, 2'h0, 4, 8'hff);
    idle();
    tick(20);
    chk(10'(q.size()), 10'h000);
    complete_run();
  end
endmodule
